// *** include/dsp_addr_pkg.sv ***
// Constants and types for the DSP data addressing and load alignment block
package dsp_addr_pkg;

  // Operation kinds presented at the issue port
  typedef enum logic [1:0] {
    OP_NONE   = 2'b00,
    OP_XY     = 2'b01,
    OP_SINGLE = 2'b10
  } op_kind_t;

  // Pointer update for X and Y memory moves
  typedef enum logic [1:0] {
    XY_NOUPD = 2'b00,
    XY_INC   = 2'b01,
    XY_INDEX = 2'b10
  } xy_mode_t;

  // Pointer update for single-data moves
  typedef enum logic [1:0] {
    S_NOUPD = 2'b00,
    S_INC   = 2'b01,
    S_INDEX = 2'b10,
    S_DEC   = 2'b11
  } single_mode_t;

  // DSP data registers; codes 8 and 9 are the accumulator guards
  typedef enum logic [3:0] {
    REG_A0 = 4'h0, REG_A1 = 4'h1, REG_M0 = 4'h2, REG_M1 = 4'h3,
    REG_X0 = 4'h4, REG_X1 = 4'h5, REG_Y0 = 4'h6, REG_Y1 = 4'h7,
    REG_G0 = 4'h8, REG_G1 = 4'h9
  } dsp_reg_t;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_BOUNDS = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_PTR    = 8'h20;  // Six pointers R2..R7
  localparam logic [7:0] OFF_XIDX   = 8'h38;
  localparam logic [7:0] OFF_YIDX   = 8'h3c;
  localparam logic [7:0] OFF_DREG   = 8'h40;  // Eight data registers
  localparam logic [7:0] OFF_G0     = 8'h60;
  localparam logic [7:0] OFF_G1     = 8'h64;

  // Field positions
  localparam int CTRL_XMOD_BIT  = 0;
  localparam int CTRL_YMOD_BIT  = 1;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_XWRAP_BIT = 1;
  localparam int STAT_YWRAP_BIT = 2;
  localparam int BOUNDS_END_LSB = 16;

  // Reset values
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam logic [7:0]  RST_GUARD = 8'h00;
  localparam logic [1:0]  RST_CTRL  = 2'h0;

  // Address steps
  localparam logic [31:0] STEP_WORD = 32'h0000_0002;
  localparam logic [31:0] STEP_LONG = 32'h0000_0004;
  localparam logic [15:0] LOW_CLEAR = 16'h0000;

endpackage

// *** include/dsp_rf_if.sv ***
// Interface between the addressing block and its DSP data register file
`timescale 1ns/10ps
interface dsp_rf_if;
  logic        rd_en;
  logic [2:0]  rd0_addr;
  logic [2:0]  rd1_addr;
  logic [31:0] rd0_data;
  logic [31:0] rd1_data;
  logic        wr0_en;
  logic [2:0]  wr0_addr;
  logic [31:0] wr0_data;
  logic        wr1_en;
  logic [2:0]  wr1_addr;
  logic [31:0] wr1_data;

  modport store (input rd_en, rd0_addr, rd1_addr, wr0_en, wr0_addr, wr0_data,
                 input wr1_en, wr1_addr, wr1_data, output rd0_data, rd1_data);
  modport user  (output rd_en, rd0_addr, rd1_addr, wr0_en, wr0_addr, wr0_data,
                 output wr1_en, wr1_addr, wr1_data, input rd0_data, rd1_data);
endinterface

// *** design/dsp_reg_file.sv ***
// Eight-word DSP data register file, two write ports, two registered reads
`timescale 1ns/10ps
module dsp_reg_file (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  dsp_rf_if.store  rf
);
  import dsp_addr_pkg::*;

  logic [31:0] word_q [0:7];
  logic [31:0] rd0_q;
  logic [31:0] rd1_q;

  // One register per entry; port 1 wins when both hit one entry
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_word
      always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
          word_q[i] <= RST_WORD;
        end else if (rf.wr1_en && rf.wr1_addr == 3'(i)) begin
          word_q[i] <= rf.wr1_data;
        end else if (rf.wr0_en && rf.wr0_addr == 3'(i)) begin
          word_q[i] <= rf.wr0_data;
        end
      end
    end
  endgenerate

  // Read data held until the next enabled read
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      rd0_q <= RST_WORD;
      rd1_q <= RST_WORD;
    end else if (rf.rd_en) begin
      rd0_q <= word_q[rf.rd0_addr];
      rd1_q <= word_q[rf.rd1_addr];
    end
  end

  assign rf.rd0_data = rd0_q;
  assign rf.rd1_data = rd1_q;
endmodule

// *** design/dsp_data_addr.sv ***
// DSP data address generation and load/store data alignment
`timescale 1ns/10ps
module dsp_data_addr (
  input  wire logic                        clk_sys_in,
  input  wire logic                        resetn_in,
  input  wire logic [7:0]                  avs_address_in,
  input  wire logic                        avs_read_in,
  input  wire logic                        avs_write_in,
  input  wire logic [31:0]                 avs_writedata_in,
  output logic [31:0]                      avs_readdata_out,
  output logic                             avs_waitrequest_out,
  input  wire logic                        op_valid_in,
  output logic                             op_ready_out,
  input  wire dsp_addr_pkg::op_kind_t      op_kind_in,
  input  wire logic                        x_move_en_in,
  input  wire dsp_addr_pkg::xy_mode_t      x_mode_in,
  input  wire logic                        x_ptr_sel_in,
  input  wire logic                        x_store_in,
  input  wire logic                        x_reg_sel_in,
  input  wire logic                        y_move_en_in,
  input  wire dsp_addr_pkg::xy_mode_t      y_mode_in,
  input  wire logic                        y_ptr_sel_in,
  input  wire logic                        y_store_in,
  input  wire logic                        y_reg_sel_in,
  input  wire dsp_addr_pkg::single_mode_t  single_mode_in,
  input  wire logic [1:0]                  single_ptr_sel_in,
  input  wire logic                        single_long_in,
  input  wire logic                        single_store_in,
  input  wire dsp_addr_pkg::dsp_reg_t      single_reg_in,
  output logic                             x_mem_req_out,
  output logic                             x_mem_we_out,
  output logic [31:0]                      x_mem_addr_out,
  output logic [15:0]                      x_mem_wdata_out,
  input  wire logic [15:0]                 x_mem_rdata_in,
  output logic                             y_mem_req_out,
  output logic                             y_mem_we_out,
  output logic [31:0]                      y_mem_addr_out,
  output logic [15:0]                      y_mem_wdata_out,
  input  wire logic [15:0]                 y_mem_rdata_in,
  input  wire logic                        fetch_req_in,
  output logic                             fetch_grant_out,
  output logic                             load_req_out,
  output logic                             load_we_out,
  output logic                             load_long_out,
  output logic [31:0]                      load_address_bus_out,
  output logic [31:0]                      load_wdata_out,
  input  wire logic [31:0]                 load_data_bus_in,
  input  wire logic                        load_ack_in
);
  import dsp_addr_pkg::*;

  dsp_rf_if rf ();

  dsp_reg_file u_rf (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .rf         (rf)
  );

  // Architectural state
  logic [31:0] ptr_q [0:5];   // R2..R7
  logic [31:0] ptr_d [0:5];
  logic [31:0] x_index_q, y_index_q;
  logic [31:0] bounds_q;
  logic [1:0]  ctrl_q;
  logic [7:0]  guard_q [0:1];
  logic [7:0]  guard_d [0:1];
  logic        x_wrap_q, y_wrap_q;
  logic        av_ack_q;
  // Memory stage state
  logic        m_valid_q;
  op_kind_t    m_kind_q;
  logic        m_x_en_q, m_x_store_q, m_x_reg_q, m_x_sel_q;
  logic        m_y_en_q, m_y_store_q, m_y_reg_q, m_y_sel_q;
  logic        m_s_store_q, m_s_long_q;
  dsp_reg_t    m_s_reg_q;
  logic [7:0]  m_guard_q;
  logic [31:0] x_addr_q, y_addr_q, s_addr_q;

  // Issue and bus handshakes
  wire         av_req     = avs_read_in | avs_write_in;
  wire         av_wr_fire = av_ack_q & avs_write_in;
  wire         fire       = op_valid_in & op_ready_out;
  wire         fire_xy    = fire & (op_kind_in == OP_XY);
  wire         fire_s     = fire & (op_kind_in == OP_SINGLE);
  wire         m_xy       = m_valid_q & (m_kind_q == OP_XY);
  wire         m_s        = m_valid_q & (m_kind_q == OP_SINGLE);
  wire         s_done     = load_req_out & load_ack_in;
  wire         m_done     = m_xy | s_done;

  assign op_ready_out        = ~m_valid_q & ~av_req & ~av_ack_q;
  assign avs_waitrequest_out = ~av_ack_q;

  // Modulo bounds: end in the upper half, start in the lower half
  wire [15:0]  mod_end   = bounds_q[31:BOUNDS_END_LSB];
  wire [15:0]  mod_start = bounds_q[BOUNDS_END_LSB-1:0];
  wire         y_mod_on  = ctrl_q[CTRL_YMOD_BIT];
  wire         x_mod_on  = ctrl_q[CTRL_XMOD_BIT] & ~y_mod_on;

  // X pointer step and wrap; 16-bit compare bounds the span to 64 kbytes
  wire [2:0]   x_idx  = {2'b01, x_ptr_sel_in};
  wire [31:0]  x_base = ptr_q[x_idx];
  wire [31:0]  x_step = (x_mode_in == XY_INC)   ? STEP_WORD :
                        (x_mode_in == XY_INDEX) ? x_index_q : RST_WORD;
  wire         x_wrap = x_mod_on & (x_mode_in != XY_NOUPD) &
                        (x_base[15:1] == mod_end[15:1]);
  wire [31:0]  x_next = x_wrap ? {x_base[31:16], mod_start[15:1], x_base[0]}
                               : x_base + x_step;

  // Y pointer step and wrap
  wire [2:0]   y_idx  = {2'b10, y_ptr_sel_in};
  wire [31:0]  y_base = ptr_q[y_idx];
  wire [31:0]  y_step = (y_mode_in == XY_INC)   ? STEP_WORD :
                        (y_mode_in == XY_INDEX) ? y_index_q : RST_WORD;
  wire         y_wrap = y_mod_on & (y_mode_in != XY_NOUPD) &
                        (y_base[15:1] == mod_end[15:1]);
  wire [31:0]  y_next = y_wrap ? {y_base[31:16], mod_start[15:1], y_base[0]}
                               : y_base + y_step;

  // Single pointer: never wraps, decrement is applied before access
  wire [2:0]   s_idx  = {1'b0, single_ptr_sel_in};
  wire [31:0]  s_base = ptr_q[s_idx];
  wire [31:0]  s_size = single_long_in ? STEP_LONG : STEP_WORD;
  wire [31:0]  s_step = (single_mode_in == S_INC)   ? s_size :
                        (single_mode_in == S_INDEX) ? x_index_q :
                        (single_mode_in == S_DEC)   ? (RST_WORD - s_size) : RST_WORD;
  wire [31:0]  s_next = s_base + s_step;
  wire [31:0]  s_addr = (single_mode_in == S_DEC) ? s_next : s_base;

  // Pointer next values, one per pointer register
  genvar i;
  generate
    for (i = 0; i < 6; i = i + 1) begin : g_ptr
      wire av_hit = av_wr_fire & (avs_address_in == OFF_PTR + 8'(4 * i));
      assign ptr_d[i] = av_hit ? avs_writedata_in :
                        (fire_xy & x_move_en_in & x_idx == 3'(i)) ? x_next :
                        (fire_xy & y_move_en_in & y_idx == 3'(i)) ? y_next :
                        (fire_s & s_idx == 3'(i)) ? s_next : ptr_q[i];
      always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
          ptr_q[i] <= RST_WORD;
        end else begin
          ptr_q[i] <= ptr_d[i];
        end
      end
    end
  endgenerate

  // Single load alignment into data register or guard
  wire         s_is_guard = m_s_reg_q[3];
  wire [31:0]  ld_aligned = m_s_long_q ? load_data_bus_in
                          : {load_data_bus_in[15:0], LOW_CLEAR};
  wire [7:0]   ld_sign    = {8{m_s_long_q ? load_data_bus_in[31] : load_data_bus_in[15]}};
  wire         s_ld_fire  = s_done & ~m_s_store_q;

  // Guard next values
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_guard
      wire av_hit = av_wr_fire & (avs_address_in == OFF_G0 + 8'(4 * i));
      assign guard_d[i] =
        av_hit ? avs_writedata_in[7:0] :
        (s_ld_fire & s_is_guard & m_s_reg_q[0] == 1'(i)) ? load_data_bus_in[7:0] :
        (s_ld_fire & ~s_is_guard & m_s_reg_q[2:0] == 3'(i)) ? ld_sign :
        guard_q[i];
    end
  endgenerate

  // Register file ports: host access when idle, else the move stages
  assign rf.rd_en    = fire | (av_req & ~m_valid_q & ~av_ack_q);
  assign rf.rd0_addr = av_req ? avs_address_in[4:2] :
                       (op_kind_in == OP_XY) ? {2'b00, x_reg_sel_in} : single_reg_in[2:0];
  assign rf.rd1_addr = {2'b00, y_reg_sel_in};
  assign rf.wr0_en   = (av_wr_fire & avs_address_in[7:5] == OFF_DREG[7:5]) |
                       (m_xy & m_x_en_q & ~m_x_store_q) | (s_ld_fire & ~s_is_guard);
  assign rf.wr0_addr = av_ack_q ? avs_address_in[4:2] :
                       m_xy ? {2'b10, m_x_reg_q} : m_s_reg_q[2:0];
  assign rf.wr0_data = av_ack_q ? avs_writedata_in :
                       m_xy ? {x_mem_rdata_in, LOW_CLEAR} : ld_aligned;
  assign rf.wr1_en   = m_xy & m_y_en_q & ~m_y_store_q;
  assign rf.wr1_addr = {2'b11, m_y_reg_q};
  assign rf.wr1_data = {y_mem_rdata_in, LOW_CLEAR};

  // Dedicated X/Y memory buses, word wide, old pointer, bit 0 forced low
  assign x_mem_req_out   = m_xy & m_x_en_q;
  assign x_mem_we_out    = x_mem_req_out & m_x_store_q;
  assign x_mem_addr_out  = x_addr_q;
  assign x_mem_wdata_out = rf.rd0_data[31:16];
  assign y_mem_req_out   = m_xy & m_y_en_q;
  assign y_mem_we_out    = y_mem_req_out & m_y_store_q;
  assign y_mem_addr_out  = y_addr_q;
  assign y_mem_wdata_out = rf.rd1_data[31:16];

  // Shared load bus; instruction fetch wins a conflict
  assign fetch_grant_out      = fetch_req_in;
  assign load_req_out         = m_s & ~fetch_req_in;
  assign load_we_out          = load_req_out & m_s_store_q;
  assign load_long_out        = m_s_long_q;
  assign load_address_bus_out = s_addr_q;

  // Single store alignment
  wire [31:0]  st_word  = s_is_guard ? {LOW_CLEAR, {8{m_guard_q[7]}}, m_guard_q}
                                     : {LOW_CLEAR, rf.rd0_data[31:16]};
  wire [31:0]  st_long  = s_is_guard ? {{24{m_guard_q[7]}}, m_guard_q}
                                     : rf.rd0_data;
  assign load_wdata_out = m_s_long_q ? st_long : st_word;

  // Host read mux for non-file registers
  wire [31:0]  stat_word = {29'h0, y_wrap_q, x_wrap_q, m_valid_q};
  wire [31:0]  av_rmux =
    (avs_address_in == OFF_CTRL)   ? {30'h0, ctrl_q} :
    (avs_address_in == OFF_BOUNDS) ? bounds_q :
    (avs_address_in == OFF_STATUS) ? stat_word :
    (avs_address_in >= OFF_PTR && avs_address_in < OFF_XIDX) ?
      ptr_q[3'(avs_address_in[4:2] - 3'h0) + 3'h0] :
    (avs_address_in == OFF_XIDX)   ? x_index_q :
    (avs_address_in == OFF_YIDX)   ? y_index_q :
    (avs_address_in == OFF_G0)     ? {24'h0, guard_q[0]} :
    (avs_address_in == OFF_G1)     ? {24'h0, guard_q[1]} : RST_WORD;
  wire         av_is_rf = (avs_address_in[7:5] == OFF_DREG[7:5]);
  assign avs_readdata_out = (av_ack_q & av_is_rf) ? rf.rd0_data : (av_ack_q ? av_rmux : RST_WORD);

  // Host handshake and control registers; ctrl written after bounds by software
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      av_ack_q  <= 1'b0;
      ctrl_q    <= RST_CTRL;
      bounds_q  <= RST_WORD;
      x_index_q <= RST_WORD;
      y_index_q <= RST_WORD;
      guard_q[0] <= RST_GUARD;
      guard_q[1] <= RST_GUARD;
    end else begin
      av_ack_q   <= av_req & ~av_ack_q & ~m_valid_q;
      guard_q[0] <= guard_d[0];
      guard_q[1] <= guard_d[1];
      if (av_wr_fire && avs_address_in == OFF_CTRL) begin
        ctrl_q <= avs_writedata_in[1:0];
      end
      if (av_wr_fire && avs_address_in == OFF_BOUNDS) begin
        bounds_q <= avs_writedata_in;
      end
      if (av_wr_fire && avs_address_in == OFF_XIDX) begin
        x_index_q <= avs_writedata_in;
      end
      if (av_wr_fire && avs_address_in == OFF_YIDX) begin
        y_index_q <= avs_writedata_in;
      end
    end
  end

  // Memory stage capture at issue
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      m_valid_q <= 1'b0;
      m_kind_q  <= OP_NONE;
      {m_x_en_q, m_x_store_q, m_x_reg_q, m_x_sel_q} <= 4'h0;
      {m_y_en_q, m_y_store_q, m_y_reg_q, m_y_sel_q} <= 4'h0;
      {m_s_store_q, m_s_long_q} <= 2'h0;
      m_s_reg_q <= REG_A0;
      m_guard_q <= RST_GUARD;
      x_addr_q  <= RST_WORD;
      y_addr_q  <= RST_WORD;
      s_addr_q  <= RST_WORD;
      x_wrap_q  <= 1'b0;
      y_wrap_q  <= 1'b0;
    end else if (fire) begin
      m_valid_q <= (op_kind_in != OP_NONE);
      m_kind_q  <= op_kind_in;
      {m_x_en_q, m_x_store_q, m_x_reg_q, m_x_sel_q} <=
        {x_move_en_in, x_store_in, x_reg_sel_in, x_ptr_sel_in};
      {m_y_en_q, m_y_store_q, m_y_reg_q, m_y_sel_q} <=
        {y_move_en_in, y_store_in, y_reg_sel_in, y_ptr_sel_in};
      {m_s_store_q, m_s_long_q} <= {single_store_in, single_long_in};
      m_s_reg_q <= single_reg_in;
      m_guard_q <= guard_q[single_reg_in[0]];
      x_addr_q  <= {x_base[31:1], 1'b0};
      y_addr_q  <= {y_base[31:1], 1'b0};
      s_addr_q  <= s_addr;
      x_wrap_q  <= fire_xy & x_move_en_in & x_wrap;
      y_wrap_q  <= fire_xy & y_move_en_in & y_wrap;
    end else if (m_done) begin
      m_valid_q <= 1'b0;
    end
  end

  // Checks
  wire [31:0] x_ptr_m = ptr_q[{2'b01, m_x_sel_q}];
  sequence s_x_wrap_issue;
    fire_xy & x_move_en_in & x_wrap;
  endsequence
  sequence s_x_noupd_issue;
    fire_xy & x_move_en_in & (x_mode_in == XY_NOUPD);
  endsequence

  a_xy_wrap_value: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    s_x_wrap_issue |=> (x_ptr_m[15:1] == $past(mod_start[15:1])) &&
                       (x_ptr_m[31:16] == $past(x_base[31:16])))
    else $error("X pointer did not wrap to modulo start");
  a_noupd_hold: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    s_x_noupd_issue |=> x_ptr_m == $past(x_base))
    else $error("No-update X move changed its pointer");
  a_both_mod_x: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (fire_xy & y_mod_on & x_move_en_in & x_mode_in == XY_INC)
      |=> x_ptr_m == $past(x_base) + STEP_WORD)
    else $error("X pointer wrapped while Y modulo was enabled");
  a_xy_old_addr: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (fire_xy & x_move_en_in) |=> x_mem_req_out &&
      x_mem_addr_out == {$past(x_base[31:1]), 1'b0} && !op_ready_out ##1 !x_mem_req_out)
    else $error("X access address not the pre-update pointer");
  a_single_nomod: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (fire_s & single_mode_in == S_INC & !single_long_in)
      |=> ptr_q[$past(s_idx)] == $past(s_base) + STEP_WORD)
    else $error("Single move pointer did not step by two");
  a_dec_preupd: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (fire_s & single_mode_in == S_DEC & single_long_in)
      |=> load_address_bus_out == $past(s_base) - STEP_LONG)
    else $error("Decrement access did not use the updated address");
  a_word_load: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (s_ld_fire & !m_s_long_q & !s_is_guard) |-> rf.wr0_en &&
      rf.wr0_data == {load_data_bus_in[15:0], LOW_CLEAR})
    else $error("Word load not placed in upper half");
  a_guard_store: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (load_req_out & m_s_store_q & m_s_long_q & s_is_guard)
      |-> load_wdata_out[31:8] == {24{m_guard_q[7]}})
    else $error("Guard longword store not sign extended");
  a_fetch_wins: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (m_s & fetch_req_in) |-> !load_req_out ##1 m_valid_q)
    else $error("Load bus driven during instruction fetch");
endmodule

// *** verif/mem_model.sv ***
// Far-side model: X/Y data memories and the shared load bus
`timescale 1ns/10ps
module mem_model (
  input  wire logic        clk_sys_in,
  input  wire logic        x_mem_req_out,
  input  wire logic [31:0] x_mem_addr_out,
  input  wire logic        y_mem_req_out,
  input  wire logic [31:0] y_mem_addr_out,
  input  wire logic        load_req_out,
  input  wire logic [31:0] ld_val_in,
  input  wire logic        slow_in,
  output logic [15:0]      x_mem_rdata_in,
  output logic [15:0]      y_mem_rdata_in,
  output logic [31:0]      load_data_bus_in,
  output logic             load_ack_in
);
  logic [1:0]  wait_q = 2'h0;
  logic [15:0] junk_q = 16'h0;
  // Word data valid in the request cycle, scrambled when idle
  assign x_mem_rdata_in = x_mem_req_out ? ~x_mem_addr_out[15:0] : junk_q;
  assign y_mem_rdata_in = y_mem_req_out ? ~y_mem_addr_out[15:0] : ~junk_q;
  assign load_ack_in = load_req_out && (wait_q == 2'h3 || !slow_in);
  assign load_data_bus_in = load_ack_in ? ld_val_in : {junk_q, ~junk_q};
  // Slow answers wait three cycles; idle pattern moves every cycle
  always @(posedge clk_sys_in) begin
    junk_q <= junk_q + 16'h1357;
    wait_q <= (load_req_out && !load_ack_in) ? wait_q + 2'h1 : 2'h0;
  end
endmodule

// *** verif/tb_top.sv ***
// Self-checking bench for the DSP data addressing block
`timescale 1ns/10ps
module tb_top;
  import dsp_addr_pkg::*;
  logic clk_sys_in = 0, resetn_in = 0, avs_read_in = 0, avs_write_in = 0, op_valid_in = 0;
  logic x_move_en_in = 0, x_ptr_sel_in = 0, x_store_in = 0, x_reg_sel_in = 0, slow_in = 0;
  logic y_move_en_in = 0, y_ptr_sel_in = 0, y_store_in = 0, y_reg_sel_in = 0;
  logic single_long_in = 0, single_store_in = 0, fetch_req_in = 0, load_ack_in;
  logic avs_waitrequest_out, op_ready_out, x_mem_req_out, x_mem_we_out, y_mem_req_out;
  logic y_mem_we_out, fetch_grant_out, load_req_out, load_we_out, load_long_out;
  logic [1:0]  single_ptr_sel_in = 0;
  logic [7:0]  avs_address_in = 0;
  logic [15:0] x_mem_wdata_out, x_mem_rdata_in, y_mem_wdata_out, y_mem_rdata_in;
  logic [31:0] avs_writedata_in = 0, avs_readdata_out, x_mem_addr_out, y_mem_addr_out;
  logic [31:0] load_address_bus_out, load_wdata_out, load_data_bus_in, ld_val_in = 0;
  logic [31:0] rd, v, idx, seed = 32'hd044, ptr [2];
  op_kind_t     op_kind_in = OP_NONE;
  xy_mode_t     x_mode_in = XY_NOUPD, y_mode_in = XY_NOUPD;
  single_mode_t single_mode_in = S_NOUPD;
  dsp_reg_t     single_reg_in = REG_A0;
  int n_fail = 0, cmp_count = 0, i;
  always #2 clk_sys_in = ~clk_sys_in;
  dsp_data_addr dut (.*);
  mem_model partner (.*);
  // Xorshift source of repeatable random values
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Expected X pointer step for a mode code
  function automatic logic [31:0] xy_step(input logic [1:0] m);
    return (m == 2'h1) ? STEP_WORD : (m == 2'h2) ? idx : 32'h0;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic hang();
    n_fail++;
    close_out();
  endtask
  // Avalon access held until waitrequest is sampled low
  task automatic av(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= we;
    avs_read_in <= !we;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys_in);
      if (!avs_waitrequest_out) break;
    end
    if (i == 50) hang();
    rd = avs_readdata_out;
    avs_write_in <= 0;
    avs_read_in <= 0;
  endtask
  // Move request held until accepted
  task automatic issue(input op_kind_t k);
    @(posedge clk_sys_in);
    op_kind_in <= k;
    op_valid_in <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys_in);
      if (op_ready_out) break;
    end
    if (i == 50) hang();
    op_valid_in <= 0;
  endtask
  // X/Y move: both memory requests checked inside their one-cycle window
  task automatic xmove(input logic [31:0] a, input logic [31:0] b);
    issue(OP_XY);
    @(negedge clk_sys_in);
    check(x_mem_req_out, x_move_en_in);
    check(x_mem_addr_out, a);
    check(x_mem_we_out, x_move_en_in & x_store_in);
    check(x_mem_wdata_out, 16'hc35a);
    check(y_mem_req_out, y_move_en_in);
    check(y_mem_we_out, y_move_en_in & y_store_in);
    if (y_move_en_in) check(y_mem_addr_out, b);
    if (y_move_en_in) check(y_mem_wdata_out, 16'hc35a);
    @(posedge clk_sys_in);
  endtask
  // Single move: fetch wins the bus, then wait for the answer
  task automatic sm(input logic [31:0] ea, input logic [31:0] ew);
    issue(OP_SINGLE);
    @(negedge clk_sys_in);
    check(load_req_out, !fetch_req_in);
    check(fetch_grant_out, fetch_req_in);
    @(posedge clk_sys_in);
    fetch_req_in <= 0;
    for (i = 0; i < 50 && !(load_req_out && load_ack_in); i++) @(posedge clk_sys_in);
    if (i == 50) hang();
    check(load_address_bus_out, ea);
    check(load_we_out, single_store_in);
    check(load_long_out, single_long_in);
    if (single_store_in) begin
      check(single_long_in ? load_wdata_out : load_wdata_out[15:0], ew);
    end
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_sys_in);
    resetn_in <= 1;
    check(avs_waitrequest_out, 1);
    av(1, OFF_BOUNDS, 32'h7004_7000);
    av(0, OFF_BOUNDS, 0);
    check(rd, 32'h7004_7000);
    av(0, 8'hfc, 0);
    check(rd, 0);
    av(1, OFF_DREG, 32'hc35a_1234);
    av(1, 8'h28, 32'ha500_7000);
    av(1, OFF_CTRL, 1);
    x_move_en_in <= 1;
    x_mode_in <= XY_INC;
    for (int k = 0; k < 4; k++) xmove(32'ha500_7000 + (k % 3) * 2, 0);
    av(0, 8'h50, 0);
    check(rd, 32'h8fff_0000);
    av(1, 8'h30, 32'h1234_7004);
    av(1, 8'h28, 32'h1234_7004);
    av(1, OFF_CTRL, 3);
    y_move_en_in <= 1;
    xmove(32'h1234_7004, 32'h1234_7004);
    y_mode_in <= XY_INC;
    xmove(32'h1234_7006, 32'h1234_7004);
    y_move_en_in <= 0;
    av(0, 8'h28, 0);
    check(rd, 32'h1234_7008);
    av(0, 8'h30, 0);
    check(rd, 32'h1234_7000);
    av(0, OFF_STATUS, 0);
    check(rd, 32'h0000_0004);
    av(1, 8'h28, 32'h1234_7002);
    av(1, OFF_XIDX, 32'h4);
    av(1, OFF_CTRL, 1);
    x_mode_in <= XY_INDEX;
    for (int k = 0; k < 3; k++) xmove(32'h1234_7002 + k * 4, 0);
    av(1, OFF_CTRL, 0);
    idx = xs() & 32'hffff_fffe;
    av(1, OFF_XIDX, idx);
    ptr[0] = 32'h1234_700e;
    ptr[1] = 0;
    for (int k = 0; k < 30; k++) begin
      v = xs();
      x_ptr_sel_in <= v[2];
      x_store_in <= v[3];
      x_mode_in <= xy_mode_t'(v[1:0] % 2'h3);
      xmove(ptr[v[2]], 0);
      ptr[v[2]] += xy_step(v[1:0] % 2'h3);
    end
    av(1, OFF_PTR, 32'h7006);
    av(1, OFF_CTRL, 1);
    fetch_req_in <= 1;
    single_mode_in <= S_DEC;
    ld_val_in <= 32'h0000_8123;
    sm(32'h7004, 0);
    av(0, OFF_DREG, 0);
    check(rd, 32'h8123_0000);
    av(0, OFF_G0, 0);
    check(rd, 32'h0000_00ff);
    single_mode_in <= S_INC;
    single_long_in <= 1;
    single_reg_in <= REG_G1;
    ld_val_in <= 32'h1234_56a5;
    slow_in <= v[0];
    sm(32'h7004, 0);
    av(0, OFF_G1, 0);
    check(rd, 32'h0000_00a5);
    single_store_in <= 1;
    sm(32'h7008, 32'hffff_ffa5);
    single_long_in <= 0;
    sm(32'h700c, 32'h0000_ffa5);
    single_mode_in <= S_DEC;
    single_long_in <= 1;
    sm(32'h700a, 32'hffff_ffa5);
    single_mode_in <= S_NOUPD;
    single_long_in <= 0;
    sm(32'h700a, 32'h0000_ffa5);
    single_mode_in <= S_INDEX;
    sm(32'h700a, 32'h0000_ffa5);
    av(0, OFF_PTR, 0);
    check(rd, 32'h700a + idx);
    single_store_in <= 0;
    single_long_in <= 1;
    single_mode_in <= S_NOUPD;
    single_reg_in <= REG_A1;
    ld_val_in <= 32'h8765_4321;
    sm(32'h700a + idx, 0);
    av(0, 8'h44, 0);
    check(rd, 32'h8765_4321);
    av(0, OFF_G1, 0);
    check(rd, 32'h0000_00ff);
    close_out();
  end
endmodule
